// ===== hdl/erase_status_flags.sv
// Contract
// - Error flag shows any failed erase since the last clear, 1 fails
// - Protected-sector erase request sets the error flag
// - Error sticks until clear-status or reset
// - No return to standby while error set
// - Suspended flag reads 1 while erase suspended
// - Ready flag 0 busy, 1 standby
//
// Purpose: Erase error, erase suspend and ready flags of the volatile
//          status register.
// Assumes: All inputs synchronous to clk; host reads status_byte.
// Notes:   Flags are read-only; only clear-status and resets clear the error flag.
`timescale 1ns/100ps
`include "erase_status_defines.svh"
module erase_status_flags
  import erase_status_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          srst,
  // Erase engine events and levels.
  input  wire erase_event_s  ev,
  input  wire logic          op_active,
  input  wire logic          erase_in_suspend,
  // Status outputs.
  output status_flags_s      flags,
  output logic [7:0]         status_byte
);

  ////////////////////////////////////////////////////////////////////////
  // Erase error flag.

  logic err_set;
  logic err_clr;
  logic err_flag;

  // Failure or protected request sets; clear-status or soft reset clears.
  assign err_set = (ev.erase_done & ev.erase_fail)
                 | ev.erase_protected;
  assign err_clr = ev.clear_status | ev.soft_reset;

  // Only clear-status or a reset may drop a set error; a later passing
  // erase must not hide the failure from the host.
  logic err_clr_all;
  assign err_clr_all = err_clr;

  sticky_flag #(.RESET_VAL(`STAT_ERR_RESET)) u_err
  (
    .clk      (clk),
    .srst     (srst),
    .set      (err_set),
    .clr      (err_clr_all),
    .flag_reg (err_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Suspend flag and device state.

  logic       susp_reg;
  logic       susp_next;
  dev_state_e state_reg;
  dev_state_e state_next;

  assign susp_next = ev.soft_reset ? `STAT_SUSPEND_RESET
                                   : erase_in_suspend;

  // Error hold keeps the device out of standby until the flag clears.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY:
        if (err_set)
          state_next = ST_ERRHOLD;
        else if (op_active)
          state_next = ST_BUSY;
      ST_BUSY:
        if (err_set)
          state_next = ST_ERRHOLD;
        else if (!op_active)
          state_next = ST_STANDBY;
      ST_ERRHOLD:
        if (err_clr && !err_set)
          state_next = op_active ? ST_BUSY : ST_STANDBY;
      default:
        state_next = ST_STANDBY;
    endcase
  end

  // Registered flags and state; srst also returns to standby.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      susp_reg  <= `STAT_SUSPEND_RESET;
      state_reg <= ST_STANDBY;
    end
    else
    begin
      susp_reg  <= susp_next;
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers.

  status_flags_s flags_next;
  logic [7:0]    byte_next;

  // Ready is 1 only in standby, never while the error is held.
  assign flags_next.device_ready_flag    = (state_next == ST_STANDBY);
  assign flags_next.erase_suspended_flag = susp_next;
  assign flags_next.erase_error_flag     =
    err_set | (err_flag & ~err_clr_all);

  always_comb
  begin
    byte_next = 8'h00;
    byte_next[`STAT_READY_BIT]     = flags_next.device_ready_flag;
    byte_next[`STAT_SUSPEND_BIT]   = flags_next.erase_suspended_flag;
    byte_next[`STAT_ERASE_ERR_BIT] = flags_next.erase_error_flag;
  end

  // Outputs straight from flip-flops, aligned with internal flag state.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flags       <= '{`STAT_READY_RESET, `STAT_SUSPEND_RESET,
                       `STAT_ERR_RESET};
      status_byte <= 8'h80;
    end
    else
    begin
      flags       <= flags_next;
      status_byte <= byte_next;
    end
  end

endmodule

// ===== pkg/erase_status_defines.svh
// Purpose: Bit positions, reset values and field constants of the erase
//          status flags.
// Assumes: Included by bare name; definitions only.
// Notes:   Positions follow the volatile status register layout.
`ifndef ERASE_STATUS_DEFINES_SVH
`define ERASE_STATUS_DEFINES_SVH

`define STAT_READY_BIT     3'h7
`define STAT_SUSPEND_BIT   3'h6
`define STAT_ERASE_ERR_BIT 3'h5
`define STAT_ERR_RESET     1'h0
`define STAT_SUSPEND_RESET 1'h0
`define STAT_READY_RESET   1'h1
`define STAT_WIDTH         8

`endif

// ===== pkg/erase_status_pkg.sv
// Purpose: Types shared by the erase status flag logic.
// Assumes: Nothing beyond the defines header.
// Notes:   Event and status structs carry related signals together.
package erase_status_pkg;

  // Events reported by the erase engine and the command decoder.
  typedef struct packed {
    logic erase_done;      // Erase finished this cycle.
    logic erase_fail;      // Finished erase failed.
    logic erase_protected; // Erase refused on a protected sector.
    logic clear_status;    // Clear-status command decoded.
    logic soft_reset;      // Software reset decoded.
  } erase_event_s;

  // Flag snapshot presented to the status read path.
  typedef struct packed {
    logic device_ready_flag;
    logic erase_suspended_flag;
    logic erase_error_flag;
  } status_flags_s;

  // Device activity states.
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h1,
    ST_BUSY    = 3'h2,
    ST_ERRHOLD = 3'h4
  } dev_state_e;

endpackage

// ===== hdl/sticky_flag.sv
// Purpose: One sticky status bit with set priority over clear.
// Assumes: Synchronous active-high reset.
// Notes:   A set in the clearing cycle wins so no event is lost.
`timescale 1ns/100ps
module sticky_flag
#(
  parameter logic RESET_VAL = 1'h0
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Control.
  input  wire logic set,
  input  wire logic clr,
  // State.
  output logic      flag_reg
);

  logic flag_next;

  // Set beats clear; clear beats hold.
  assign flag_next = set ? 1'h1 : (clr ? 1'h0 : flag_reg);

  // Flag storage.
  always_ff @(posedge clk)
  begin
    if (srst)
      flag_reg <= RESET_VAL;
    else
      flag_reg <= flag_next;
  end

endmodule

// ===== test/erase_status_flags_assertions.sv
// Purpose: Concurrent checks on the erase status flag outputs.
// Assumes: Outputs follow their cause one edge later.
// Notes:   Bound to the design; watches ports only.
`timescale 1ns/100ps
module erase_status_flags_assertions
  import erase_status_pkg::*;
(
  // Watched ports.
  input wire logic          clk,
  input wire logic          srst,
  input wire erase_event_s  ev,
  input wire logic          op_active,
  input wire logic          erase_in_suspend,
  input wire status_flags_s flags,
  input wire logic [7:0]    status_byte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // A set beats any clear, so set causes need no side conditions.
  a_fail_sets: assert property (ev.erase_done && ev.erase_fail
    |=> flags.erase_error_flag) else $error("fail not flagged");
  a_prot_sets: assert property (ev.erase_protected
    |=> flags.erase_error_flag) else $error("protect not flagged");
  a_err_sticks: assert property (flags.erase_error_flag
    && !ev.clear_status && !ev.soft_reset
    |=> flags.erase_error_flag) else $error("error lost");
  a_clr_works: assert property ((ev.clear_status || ev.soft_reset)
    && !ev.erase_protected && !ev.erase_done
    |=> !flags.erase_error_flag) else $error("error not cleared");
  a_no_standby: assert property (flags.erase_error_flag
    |-> !flags.device_ready_flag) else $error("ready with error");
  a_susp_follow: assert property (!ev.soft_reset
    |=> flags.erase_suspended_flag == $past(erase_in_suspend))
    else $error("suspend flag wrong");
  a_ready_idle: assert property (!op_active
    |=> flags.device_ready_flag == !flags.erase_error_flag)
    else $error("ready wrong");
  a_byte_map: assert property (status_byte == {flags, 5'h00})
    else $error("byte map wrong");
endmodule
bind erase_status_flags erase_status_flags_assertions chk_i (
  .clk(clk), .srst(srst), .ev(ev), .op_active(op_active),
  .erase_in_suspend(erase_in_suspend), .flags(flags),
  .status_byte(status_byte));

// ===== test/host_model.sv
// Purpose: Host side sending erase events and command pulses.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes:   Soft reset goes alone so its effect stays clear.
`timescale 1ns/100ps
module host_model
  import erase_status_pkg::*;
(
  // Clock in, stimulus out.
  input  wire logic    clk,
  output erase_event_s ev,
  output logic         op_active,
  output logic         erase_in_suspend
);
  logic [7:0] r;
  // Anded bits keep pulses sparse so errors get time to stick.
  initial
  begin
    ev = '0;
    op_active = 1'b0;
    erase_in_suspend = 1'b0;
    forever
    begin
      @(posedge clk);
      #1;
      r = 8'($urandom);
      ev = (r[0] && r[1] && r[2]) ? 5'h01 : r[6:2] & r[7:3] & 5'h1e;
      op_active = r[4] && !ev.soft_reset;
      erase_in_suspend = r[7] && !ev.soft_reset;
    end
  end
endmodule

// ===== test/tb_top.sv
// Purpose: Self-checking bench for erase_status_flags.
// Assumes: host_model drives random traffic every cycle.
// Notes:   An integer model predicts the status byte each edge.
`timescale 1ns/100ps
module tb_top;
  import erase_status_pkg::*;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  erase_event_s  ev;
  logic          op_active;
  logic          erase_in_suspend;
  status_flags_s flags;
  logic [7:0]    status_byte;
  int            miscompares = 0, checks_done = 0, cycles = 0;
  int            e = 0, s = 0, rd = 1;
  always #20 clk = ~clk;
  host_model host (.clk(clk), .ev(ev), .op_active(op_active),
    .erase_in_suspend(erase_in_suspend));
  erase_status_flags dut (.clk(clk), .srst(srst), .ev(ev),
    .op_active(op_active), .erase_in_suspend(erase_in_suspend),
    .flags(flags), .status_byte(status_byte));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t status %h expected %h", $time, got, exp);
    end
  endtask
  // Model: set wins over clear-status but not over reset; only clear-status or reset clears.
  always @(posedge clk)
  begin
    cycles++;
    e = (srst || ev.soft_reset) ? 0 : ((ev.erase_done && ev.erase_fail)
      || ev.erase_protected || (e && !ev.clear_status));
    s = !srst && erase_in_suspend;
    rd = srst || (!op_active && !e);
    if (cycles == 3000)
    begin
      miscompares++;
      conclude();
    end
  end
  // Outputs are settled by the falling edge.
  always @(negedge clk)
  begin
    chk(status_byte, 8'({rd[0], s[0], e[0], 5'h00}));
    chk({flags, 5'h00}, 8'({rd[0], s[0], e[0], 5'h00}));
  end
  // Reset at start and once in mid-run.
  initial
  begin
    void'($urandom(32'h91b99e5d));
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    repeat (1000) @(posedge clk);
    #1 srst = 1'b1;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    repeat (1000) @(posedge clk);
    conclude();
  end
endmodule
